// [cpu_model.sv]
// cpu stand-in: retires requested instructions and keeps the mask bit
module cpu_model import exc_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire cpu_command_t cpu_command,
	input wire logic go,
	input wire logic [3:0] kind,
	input wire logic [15:0] pc,
	output cpu_status_t cpu_status
);
	logic done_q, mask_q;
	logic [3:0] kind_q;
	logic [15:0] pc_q;
	// nothing retires while gated; pc scrambles between requests so stale values show
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_q <= 1'b0;
			kind_q <= 4'h0;
			pc_q <= 16'h0;
		end else begin
			done_q <= go & cpu_command.cpu_clock_en;
			kind_q <= go ? kind : 4'h0;
			pc_q <= go ? pc : ~pc_q;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) mask_q <= 1'b1;
		else if (cpu_command.take_exception) mask_q <= 1'b1;
		else if (cpu_command.clear_mask || (done_q && kind_q[0])) mask_q <= 1'b0;
	end
	// a return has restored the mask by the time it retires
	assign cpu_status = {done_q, mask_q & ~(done_q & kind_q[0]), kind_q, pc_q};
endmodule

// [exc_pkg.sv]
// package: register map, field layout, timing counts and carrier types for the sequencer
package exc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] break_wake_status_off = 8'h00;
	localparam logic [7:0] reset_source_status_off = 8'h04;
	localparam logic [7:0] break_flag_control_off = 8'h08;

	// field positions
	localparam int break_wake_flag_pos = 1;
	localparam int break_clear_enable_pos = 7;
	localparam int rst_lvi_pos = 1;
	localparam int rst_bad_addr_pos = 3;
	localparam int rst_bad_op_pos = 4;
	localparam int rst_wdog_pos = 5;
	localparam int rst_pin_pos = 6;
	localparam int rst_por_pos = 7;

	// reset values
	localparam logic [7:0] reset_source_por_value = 8'h80;
	localparam logic [7:0] break_wake_status_reset = 8'h00;
	localparam logic [7:0] break_flag_control_reset = 8'h00;

	// stop recovery, in crystal_clock cycles
	localparam int long_recovery_cycles = 4096;
	localparam int short_recovery_cycles = 32;
	localparam int recovery_counter_width = 12;

	// interrupt source count and vector width
	localparam int irq_sources = 8;
	localparam int vec_width = 4;
	localparam logic [3:0] trap_vector = 4'hf;

	// cpu status towards the sequencer
	typedef struct packed {
		logic insn_done;
		logic mask_bit;
		logic trap_insn;
		logic wait_insn;
		logic stop_insn;
		logic rti_insn;
		logic [15:0] pc;
	} cpu_status_t;

	// sequencer commands towards the cpu
	typedef struct packed {
		logic take_exception;
		logic [3:0] vector;
		logic [15:0] stack_pc;
		logic stack_index_high;
		logic clear_mask;
		logic cpu_clock_en;
		logic discard_prefetch;
	} cpu_command_t;

	// reset cause strobes, one cycle each
	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic bad_op;
		logic bad_addr;
		logic undervoltage_flag;
	} reset_cause_t;

	typedef enum logic [3:0] {
		st_run = 4'b0001,
		st_wait = 4'b0010,
		st_stop = 4'b0100,
		st_recover = 4'b1000
	} power_state_t;

endpackage

// [exc_seq_properties.sv]
// checker: port-level properties of the sequencer
module exc_seq_properties import exc_pkg::*; #(
	parameter int irq_count = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire cpu_status_t cpu_status,
	input wire cpu_command_t cpu_command,
	input wire logic [irq_count-1:0] irq_pending,
	input wire logic [irq_count-1:0] irq_enable,
	input wire logic break_request,
	input wire reset_cause_t reset_cause,
	input wire logic watchdog_disable,
	input wire logic watchdog_run,
	input wire logic base_clock_out_en,
	input wire logic crystal_clock_en
);
	logic calm, live, plain;
	logic [3:0] first;
	// a boundary that no reset or break competes for
	assign calm = cpu_status.insn_done && !break_request && reset_cause == '0;
	assign live = |(irq_pending & irq_enable);
	assign plain = calm && cpu_status[19:16] == 4'h0;
	// index 0 wins: scan down so the lowest live bit is left
	always_comb begin
		first = 4'h0;
		for (int i = irq_count - 1; i >= 0; i--) if (irq_pending[i] & irq_enable[i]) first = 4'(i);
	end
	// set by a retired wait; stop recovery also gates the cpu, so it stays out
	logic waiting_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			waiting_q <= 1'b0;
		end else if (cpu_status.insn_done && cpu_status.wait_insn) begin
			waiting_q <= 1'b1;
		end else if (cpu_command.cpu_clock_en) begin
			waiting_q <= 1'b0;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	irq_take_a: assert property (
		plain && !cpu_status.mask_bit && live |-> ##2 cpu_command.take_exception
		&& cpu_command.vector == $past(first, 2)
		&& cpu_command.stack_pc == $past(cpu_status.pc, 2) - 16'h1) else $error("irq take");
	trap_take_a: assert property (
		calm && cpu_status.trap_insn |=> cpu_command.take_exception && cpu_command.vector ==
		trap_vector && cpu_command.stack_pc == $past(cpu_status.pc)) else $error("trap take");
	reset_wins_a: assert property (
		reset_cause != '0 |=> !cpu_command.take_exception) else $error("reset beaten");
	index_high_a: assert property (
		!cpu_command.stack_index_high) else $error("index stacked");
	wait_gate_a: assert property (
		calm && cpu_status.wait_insn && !live |=> !cpu_command.cpu_clock_en) else $error("wait");
	stop_gate_a: assert property (
		calm && cpu_status.stop_insn && !live |=> !crystal_clock_en && !base_clock_out_en)
		else $error("stop clocks");
	mask_drop_a: assert property (
		calm && (cpu_status.wait_insn || cpu_status.stop_insn) |-> ##[1:2] cpu_command.clear_mask)
		else $error("mask kept");
	dog_wait_a: assert property (
		waiting_q && !watchdog_disable && !cpu_command.cpu_clock_en |-> watchdog_run)
		else $error("watchdog idle");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind exception_lowpower_sequencer exc_seq_properties #(.irq_count(irq_count)) props (.hclk,
	.hresetn, .cpu_status, .cpu_command, .irq_pending, .irq_enable, .break_request,
	.reset_cause, .watchdog_disable, .watchdog_run, .base_clock_out_en, .crystal_clock_en);

// [exception_lowpower_sequencer.sv]
// exception arbitration, wait and stop sequencing, break flag protection, status registers
//
// The address map and the AHB-Lite register port are this design's own decisions.
module exception_lowpower_sequencer #(
	parameter int irq_count = exc_pkg::irq_sources,
	parameter int long_recovery = exc_pkg::long_recovery_cycles
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire exc_pkg::cpu_status_t cpu_status,
	output exc_pkg::cpu_command_t cpu_command,
	input wire logic [irq_count-1:0] irq_pending,
	input wire logic [irq_count-1:0] irq_enable,
	input wire logic break_request,
	input wire exc_pkg::reset_cause_t reset_cause,
	input wire logic crystal_tick,
	input wire logic short_recovery_select,
	input wire logic watchdog_disable,
	output logic watchdog_run,
	output logic base_clock_out_en,
	output logic crystal_clock_en,
	output logic break_mode,
	output logic flag_clear_allowed
);
	import exc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// bus slave
	logic ap_valid;
	logic wr_q;
	logic rd_q;
	logic [7:0] addr_q;
	logic [7:0] wbyte;
	logic break_wake_flag_q;
	logic [5:0] reset_flags_q;
	logic break_clear_enable_q;
	logic status_read;
	logic [7:0] reset_byte;

	assign ap_valid = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q <= ap_valid && hwrite;
			rd_q <= ap_valid && !hwrite;
			addr_q <= haddr[7:0];
		end
	end

	assign status_read = rd_q && addr_q == reset_source_status_off;

	// flags are placed by the field positions, so the map lives in one place
	always_comb begin
		reset_byte = 8'h00;
		reset_byte[rst_por_pos] = reset_flags_q[5];
		reset_byte[rst_pin_pos] = reset_flags_q[4];
		reset_byte[rst_wdog_pos] = reset_flags_q[3];
		reset_byte[rst_bad_op_pos] = reset_flags_q[2];
		reset_byte[rst_bad_addr_pos] = reset_flags_q[1];
		reset_byte[rst_lvi_pos] = reset_flags_q[0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			unique case (haddr[7:0])
				break_wake_status_off: begin
					hrdata <= 32'(break_wake_flag_q) << break_wake_flag_pos;
				end
				reset_source_status_off: begin
					hrdata <= {24'h00_0000, reset_byte};
				end
				break_flag_control_off: begin
					hrdata <= 32'(break_clear_enable_q) << break_clear_enable_pos;
				end
				default: begin
					hrdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset source flags: held until read or replaced by the next cause, set wins over the read clear
	logic [5:0] cause_vec;
	logic any_reset;
	assign cause_vec = {reset_cause.por, reset_cause.pin, reset_cause.wdog,
		reset_cause.bad_op, reset_cause.bad_addr, reset_cause.undervoltage_flag};
	assign any_reset = |cause_vec;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_flags_q <= reset_source_por_value[7:2];
		end else if (reset_cause.por) begin
			reset_flags_q <= reset_source_por_value[7:2];
		end else if (any_reset) begin
			reset_flags_q <= cause_vec;
		end else if (status_read) begin
			reset_flags_q <= 6'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			break_clear_enable_q <= break_flag_control_reset[break_clear_enable_pos];
		end else if (any_reset) begin
			break_clear_enable_q <= 1'b0;
		end else if (wr_q && addr_q == break_flag_control_off) begin
			break_clear_enable_q <= wbyte[break_clear_enable_pos];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power state machine
	power_state_t state_q;
	power_state_t state_d;
	logic [recovery_counter_width-1:0] rec_cnt_q;
	logic [recovery_counter_width-1:0] rec_limit;
	logic wake_irq;
	logic rec_done;
	logic break_wake;

	assign rec_limit = short_recovery_select
		? recovery_counter_width'(short_recovery_cycles - 1)
		: recovery_counter_width'(long_recovery - 1);
	assign wake_irq = |(irq_pending & irq_enable);
	assign rec_done = crystal_tick && rec_cnt_q == rec_limit;
	assign break_wake = break_request && (state_q == st_wait || state_q == st_stop);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			st_run: begin
				if (cpu_status.insn_done && cpu_status.stop_insn) begin
					state_d = st_stop;
				end else if (cpu_status.insn_done && cpu_status.wait_insn) begin
					state_d = st_wait;
				end
			end
			st_wait: begin
				if (wake_irq || break_request) begin
					state_d = st_run;
				end
			end
			st_stop: begin
				if (wake_irq || break_request) begin
					state_d = st_recover;
				end
			end
			st_recover: begin
				if (rec_done) begin
					state_d = st_run;
				end
			end
		endcase
		if (any_reset) begin
			state_d = st_run;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= st_run;
		end else begin
			state_q <= state_d;
		end
	end

	// crystal_tick marks a falling crystal_clock edge, sampled in this domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_cnt_q <= '0;
		end else if (state_q != st_recover) begin
			rec_cnt_q <= '0;
		end else if (crystal_tick) begin
			rec_cnt_q <= rec_cnt_q + 1'b1;
		end
	end

	// set wins over the software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			break_wake_flag_q <= break_wake_status_reset[break_wake_flag_pos];
		end else if (any_reset) begin
			break_wake_flag_q <= 1'b0;
		end else if (break_wake) begin
			break_wake_flag_q <= 1'b1;
		end else if (wr_q && addr_q == break_wake_status_off
			&& !wbyte[break_wake_flag_pos]) begin
			break_wake_flag_q <= 1'b0;
		end
	end

	assign watchdog_run = !watchdog_disable && state_q != st_stop
		&& state_q != st_recover;
	assign base_clock_out_en = state_q != st_stop;
	assign crystal_clock_en = state_q != st_stop;

	////////////////////////////////////////////////////////////////////////////
	// break mode and flag protection
	logic break_mode_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			break_mode_q <= 1'b0;
		end else if (any_reset) begin
			break_mode_q <= 1'b0;
		end else if (break_request) begin
			break_mode_q <= 1'b1;
		end else if (cpu_status.rti_insn && cpu_status.insn_done) begin
			break_mode_q <= 1'b0;
		end
	end
	assign break_mode = break_mode_q;
	// peripherals gate both steps of any clear with this, so a half-done
	// two-step clear cannot finish inside break; clears done stay done
	assign flag_clear_allowed = !break_mode_q || break_clear_enable_q;

	////////////////////////////////////////////////////////////////////////////
	// interrupt arbitration, lowest index is highest priority
	logic [irq_count-1:0] eligible;
	logic [vec_width-1:0] win_vec;
	logic win_any;
	logic boundary;
	logic latched_q;
	logic [vec_width-1:0] latched_vec_q;
	logic latched_rti_q;
	logic hw_take;
	logic trap_take;
	logic brk_take;
	logic [15:0] pc_q;

	assign eligible = irq_pending & irq_enable;

	always_comb begin
		win_vec = '0;
		win_any = 1'b0;
		for (int i = irq_count - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				win_vec = vec_width'(i);
				win_any = 1'b1;
			end
		end
	end

	// boundary: end of an instruction, or the last cycle of wait/recovery, as state_d turns to run
	assign boundary = (state_q == st_run && cpu_status.insn_done)
		|| (state_q == st_wait && state_d == st_run)
		|| (state_q == st_recover && rec_done);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latched_q <= 1'b0;
			latched_vec_q <= '0;
			latched_rti_q <= 1'b0;
		end else if (any_reset || hw_take || trap_take || brk_take) begin
			// dropped as the take is issued, so the strobe stays one cycle wide
			latched_q <= 1'b0;
		end else if (!latched_q && boundary && win_any && !cpu_status.mask_bit) begin
			latched_q <= 1'b1;
			latched_vec_q <= win_vec;
			latched_rti_q <= cpu_status.rti_insn;
		end
	end

	// a boundary includes the wake from wait or recovery, where no instruction retires
	assign brk_take = !any_reset && break_request && boundary;
	assign trap_take = !any_reset && !brk_take && state_q == st_run
		&& cpu_status.insn_done && cpu_status.trap_insn;
	assign hw_take = !any_reset && !brk_take && !trap_take && latched_q
		&& state_q == st_run;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_q <= 16'h0000;
		end else if (cpu_status.insn_done) begin
			pc_q <= cpu_status.pc;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_command <= '0;
		end else begin
			cpu_command.take_exception <= hw_take || trap_take || brk_take;
			cpu_command.vector <= hw_take ? latched_vec_q : trap_vector;
			cpu_command.stack_pc <= hw_take ? pc_q - 16'h0001 : cpu_status.pc;
			cpu_command.stack_index_high <= 1'b0;
			cpu_command.discard_prefetch <= hw_take && latched_rti_q;
			cpu_command.clear_mask <= cpu_status.insn_done && state_q == st_run
				&& (cpu_status.wait_insn || cpu_status.stop_insn);
			cpu_command.cpu_clock_en <= state_d == st_run;
		end
	end

endmodule

// [test_exception_lowpower_sequencer.sv]
// bench: bus, exception and low-power scenarios
module test_exception_lowpower_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import exc_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, break_request = 0, seen;
	logic crystal_tick = 0, short_recovery_select = 0, watchdog_disable = 0, hready;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_d;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] kind = '0;
	logic [15:0] pc = '0;
	logic [7:0] irq_pending = '0, irq_enable = '0;
	reset_cause_t reset_cause = '0;
	cpu_status_t cpu_status;
	cpu_command_t cpu_command;
	logic hreadyout, hresp, watchdog_run, base_clock_out_en, crystal_clock_en, break_mode;
	logic flag_clear_allowed;
	int err_total = 0, compares = 0, n;
	localparam int slow = 64;
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", s, e, g); end end
	exception_lowpower_sequencer #(.irq_count(8), .long_recovery(slow)) dut (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.cpu_status, .cpu_command, .irq_pending, .irq_enable, .break_request, .reset_cause,
		.crystal_tick, .short_recovery_select, .watchdog_disable, .watchdog_run,
		.base_clock_out_en, .crystal_clock_en, .break_mode, .flag_clear_allowed);
	cpu_model cpu (.hclk, .hresetn, .cpu_command, .go, .kind, .pc, .cpu_status);
	assign hready = hreadyout;
	initial forever #50 hclk = ~hclk;
	always @(posedge hclk) crystal_tick <= ~crystal_tick;
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd_d = hrdata;
		#1;
	endtask
	task automatic insn(input logic [3:0] k, input logic [15:0] p);
		@(posedge hclk);
		go <= 1'b1;
		kind <= k;
		pc <= p;
		@(posedge hclk);
		go <= 1'b0;
	endtask
	// bounded wait for the exception strobe; seen records a dropped prefetch
	task automatic await_exc(input int lim);
		n = 0;
		seen = 1'b0;
		do begin
			@(posedge hclk);
			#1;
			n++;
			seen |= cpu_command.discard_prefetch;
		end while (cpu_command.take_exception !== 1'b1 && n < lim);
	endtask
	task automatic t_regs();
		bus(1'b0, reset_source_status_off, '0);
		`CHK("por flags", 32'(reset_source_por_value), rd_d)
		`CHK("okay", 1'b0, hresp)
		bus(1'b0, reset_source_status_off, '0);
		`CHK("flags read", 32'h0, rd_d)
		bus(1'b1, break_flag_control_off, 32'hffff_ffff);
		bus(1'b0, break_flag_control_off, '0);
		`CHK("control", 32'h1 << break_clear_enable_pos, rd_d)
		bus(1'b0, 8'h0c, '0);
		`CHK("unmapped", 32'h0, rd_d)
		bus(1'b1, break_flag_control_off, '0);
	endtask
	task automatic t_causes();
		int pos[6] = '{rst_lvi_pos, rst_bad_addr_pos, rst_bad_op_pos, rst_wdog_pos,
			rst_pin_pos, rst_por_pos};
		for (int i = 0; i < 6; i++) begin
			@(posedge hclk);
			reset_cause <= reset_cause_t'(6'h1 << i);
			@(posedge hclk);
			reset_cause <= '0;
			bus(1'b0, reset_source_status_off, '0);
			`CHK("cause flag", 32'h1 << pos[i], rd_d)
		end
	endtask
	task automatic t_irq();
		insn(4'h1, 16'h0100);
		@(posedge hclk);
		irq_enable <= 8'h0e;
		irq_pending <= 8'h0d;
		insn(4'h0, 16'h1234);
		await_exc(8);
		`CHK("irq vector", 4'h2, cpu_command.vector)
		`CHK("irq pc", 16'h1233, cpu_command.stack_pc)
		insn(4'h0, 16'h1240);
		await_exc(6);
		`CHK("masked", 1'b0, cpu_command.take_exception)
		insn(4'h1, 16'h1250);
		await_exc(8);
		`CHK("prefetch dropped", 1'b1, seen)
		irq_pending <= 8'h00;
		insn(4'h8, 16'h2000);
		await_exc(8);
		`CHK("trap vector", trap_vector, cpu_command.vector)
		`CHK("trap pc", 16'h2000, cpu_command.stack_pc)
	endtask
	task automatic t_wait();
		insn(4'h4, 16'h3000);
		await_exc(3);
		`CHK("cpu clock", 1'b0, cpu_command.cpu_clock_en)
		`CHK("mask", 1'b0, cpu_status.mask_bit)
		`CHK("watchdog", 1'b1, watchdog_run)
		irq_pending <= 8'h08;
		await_exc(10);
		`CHK("wake", 1'b1, n <= 3 && cpu_command.vector === 4'h3)
		irq_pending <= 8'h00;
	endtask
	task automatic t_stop(input logic srs, input logic brk, input int lo);
		short_recovery_select <= srs;
		irq_enable <= 8'h1e;
		insn(4'h2, 16'h4000);
		await_exc(3);
		`CHK("clocks off", 2'h0, {crystal_clock_en, base_clock_out_en})
		if (brk) break_request <= 1'b1;
		else irq_pending <= 8'h10;
		await_exc(3000);
		break_request <= 1'b0;
		irq_pending <= 8'h00;
		`CHK("recovery", 1'b1, n >= 2 * lo && n <= 2 * lo + 16)
		`CHK("wake vector", brk ? trap_vector : 4'h4, cpu_command.vector)
		bus(1'b0, break_wake_status_off, '0);
		`CHK("break wake", 32'(brk) << break_wake_flag_pos, rd_d)
	endtask
	task automatic t_break();
		`CHK("guarded", 2'h2, {break_mode, flag_clear_allowed})
		bus(1'b1, break_flag_control_off, 32'h1 << break_clear_enable_pos);
		`CHK("clearable", 1'b1, flag_clear_allowed)
		bus(1'b1, break_wake_status_off, '0);
		bus(1'b0, break_wake_status_off, '0);
		`CHK("wake cleared", 32'h0, rd_d)
		insn(4'h1, 16'h4001);
		await_exc(2);
		`CHK("break over", 1'b0, break_mode)
	endtask
	task automatic report_and_stop();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_causes();
		t_irq();
		t_wait();
		t_stop(1'b0, 1'b1, slow);
		t_break();
		t_stop(1'b1, 1'b0, short_recovery_cycles);
		report_and_stop();
	end
	initial begin
		#2_000_000;
		err_total++;
		report_and_stop();
	end
endmodule
